// File: rtl/lars_consts.vh
`ifndef LARS_CONSTS_VH
`define LARS_CONSTS_VH
// register byte offsets
`define LARS_A_CTRL 8'h00
`define LARS_A_LOOP 8'h04
`define LARS_A_FRC_A 8'h08
`define LARS_A_FRC_B 8'h0C
`define LARS_A_SRC 8'h10
`define LARS_A_GAIN_A 8'h14
`define LARS_A_GAIN_B 8'h18
`define LARS_A_TIMES 8'h1C
`define LARS_A_LIMEN 8'h20
`define LARS_A_STAT 8'h24
`define LARS_A_SETPT 8'h28
`define LARS_A_LO_BASE 3'h2
`define LARS_A_HI_BASE 3'h3
// ctrl fields (self clearing)
`define LARS_CTRL_COMMIT 0
`define LARS_CTRL_CLEAR 1
// loop fields
`define LARS_LOOP_EN_A 0
`define LARS_LOOP_EN_B 1
`define LARS_LOOP_FRC_A 2
`define LARS_LOOP_FRC_B 3
`define LARS_LOOP_FRC_RLY 4
`define LARS_LOOP_MAP_LSB 8
`define LARS_LOOP_RST 13'h0001
// status fields
`define LARS_ST_ALARM_LSB 10
`define LARS_ST_RELAY 16
`define LARS_ST_FAULT_LSB 17
// alert codes
`define LARS_AL_DIS 2'h0
`define LARS_AL_OK 2'h1
`define LARS_AL_LOW 2'h2
`define LARS_AL_HIGH 2'h3
// loop current in microamps
`define LARS_I_ZERO 15'h0000
`define LARS_I_BASE 15'h0FA0
`define LARS_I_SPAN 17'h0_3E80
`define LARS_I_FULL 15'h4E20
// timing
`define LARS_CLK_HZ 125000000
`define LARS_TICK_S 1
`define LARS_RESP_OK 2'h0
`define LARS_RESP_ERR 2'h2
`endif

// File: rtl/lars_top.v
`timescale 1ns/10ps
`include "lars_consts.vh"
module lars_top #(
  parameter TICK_CYCLES = `LARS_CLK_HZ * `LARS_TICK_S
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [15:0] result_0,
  input wire [15:0] result_1,
  input wire [15:0] result_2,
  input wire [15:0] result_3,
  input wire [15:0] result_4,
  input wire loop_a_reach_ok,
  input wire loop_b_reach_ok,
  input wire clear_button,
  output reg [14:0] loop_a_setpoint,
  output reg [14:0] loop_b_setpoint,
  output reg relay_coil,
  output reg relay_no_closed,
  output reg relay_nc_closed,
  output reg power_lamp,
  output reg relay_lamp,
  output reg fault_lamp,
  output reg ui_activity,
  output reg relay_status_ind
);
  wire [15:0] res [0:4];
  assign res[0] = result_0;
  assign res[1] = result_1;
  assign res[2] = result_2;
  assign res[3] = result_3;
  assign res[4] = result_4;

  // shadow settings, written by software
  reg [12:0] sh_loop_r;
  reg [14:0] sh_frc_a_r, sh_frc_b_r;
  reg [6:0] sh_src_r;
  reg [15:0] sh_gain_a_r, sh_gain_b_r;
  reg [15:0] sh_times_r;
  reg [12:0] sh_limen_r;
  reg [15:0] sh_lo_r [0:4];
  reg [15:0] sh_hi_r [0:4];
  // active settings, used by the logic
  reg [12:0] act_loop_r;
  reg [14:0] act_frc_a_r, act_frc_b_r;
  reg [6:0] act_src_r;
  reg [15:0] act_gain_a_r, act_gain_b_r;
  reg [15:0] act_times_r;
  reg [12:0] act_limen_r;
  reg [15:0] act_lo_r [0:4];
  reg [15:0] act_hi_r [0:4];

  reg aw_have_r, w_have_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg commit_r, sw_clear_r;
  reg [31:0] tick_cnt_r;
  reg tick_r, blink_r;
  reg [1:0] reach_a_r, reach_b_r;
  reg [2:0] btn_r;
  wire [4:0] alarm_w;
  wire [9:0] alert_w;
  reg [31:0] rd_nxt;
  reg [1:0] rresp_nxt;
  integer i;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        merge[k*8 +: 8] = strb[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
      end
    end
  endfunction

  function [15:0] pick;
    input [2:0] sel;
    input [79:0] all;
    begin
      pick = (sel < 3'h5) ? all[sel*16 +: 16] : 16'h0000;
    end
  endfunction

  // bus slave; address and data may come in either order
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
  wire [31:0] wv = w_data_r;
  wire lo_hit_addr = aw_addr_r[7:5] == `LARS_A_LO_BASE && aw_addr_r[4:2] < 3'h5;
  wire hi_hit_addr = aw_addr_r[7:5] == `LARS_A_HI_BASE && aw_addr_r[4:2] < 3'h5;
  reg wr_map;
  always @* begin
    case (aw_addr_r)
      `LARS_A_CTRL, `LARS_A_LOOP, `LARS_A_FRC_A, `LARS_A_FRC_B, `LARS_A_SRC,
      `LARS_A_GAIN_A, `LARS_A_GAIN_B, `LARS_A_TIMES, `LARS_A_LIMEN: wr_map = 1'b1;
      default: wr_map = lo_hit_addr || hi_hit_addr;
    endcase
  end
  // old contents for byte-enable merge, so each register takes only its own bits
  reg [31:0] wr_old;
  wire [31:0] wr_new = merge(wr_old, wv, w_strb_r);
  always @* begin
    wr_old = 32'h0000_0000;
    case (aw_addr_r)
      `LARS_A_LOOP: wr_old = {19'h0, sh_loop_r};
      `LARS_A_FRC_A: wr_old = {17'h0, sh_frc_a_r};
      `LARS_A_FRC_B: wr_old = {17'h0, sh_frc_b_r};
      `LARS_A_SRC: wr_old = {25'h0, sh_src_r};
      `LARS_A_GAIN_A: wr_old = {16'h0, sh_gain_a_r};
      `LARS_A_GAIN_B: wr_old = {16'h0, sh_gain_b_r};
      `LARS_A_TIMES: wr_old = {16'h0, sh_times_r};
      `LARS_A_LIMEN: wr_old = {19'h0, sh_limen_r};
      default: begin
        if (lo_hit_addr) wr_old = {16'h0, sh_lo_r[aw_addr_r[4:2]]};
        else if (hi_hit_addr) wr_old = {16'h0, sh_hi_r[aw_addr_r[4:2]]};
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LARS_RESP_OK;
      commit_r <= 1'b0;
      sw_clear_r <= 1'b0;
      sh_loop_r <= `LARS_LOOP_RST;
      sh_frc_a_r <= `LARS_I_ZERO;
      sh_frc_b_r <= `LARS_I_ZERO;
      sh_src_r <= 7'h00;
      sh_gain_a_r <= 16'h0000;
      sh_gain_b_r <= 16'h0000;
      sh_times_r <= 16'h0000;
      sh_limen_r <= 13'h0000;
      for (i = 0; i < 5; i = i + 1) begin
        sh_lo_r[i] <= 16'h0000;
        sh_hi_r[i] <= 16'h0000;
      end
    end else begin
      commit_r <= 1'b0;
      sw_clear_r <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `LARS_RESP_OK : `LARS_RESP_ERR;
        case (aw_addr_r)
          `LARS_A_CTRL: begin
            commit_r <= w_strb_r[0] && wv[`LARS_CTRL_COMMIT];
            sw_clear_r <= w_strb_r[0] && wv[`LARS_CTRL_CLEAR];
          end
          `LARS_A_LOOP: sh_loop_r <= wr_new[12:0];
          `LARS_A_FRC_A: sh_frc_a_r <= wr_new[14:0];
          `LARS_A_FRC_B: sh_frc_b_r <= wr_new[14:0];
          `LARS_A_SRC: sh_src_r <= wr_new[6:0];
          `LARS_A_GAIN_A: sh_gain_a_r <= wr_new[15:0];
          `LARS_A_GAIN_B: sh_gain_b_r <= wr_new[15:0];
          `LARS_A_TIMES: sh_times_r <= wr_new[15:0];
          `LARS_A_LIMEN: sh_limen_r <= wr_new[12:0];
          default: begin
            if (lo_hit_addr) begin
              sh_lo_r[aw_addr_r[4:2]] <= wr_new[15:0];
            end
            if (hi_hit_addr) begin
              sh_hi_r[aw_addr_r[4:2]] <= wr_new[15:0];
            end
          end
        endcase
      end
    end
  end

  // commit: every active setting changes in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      act_loop_r <= `LARS_LOOP_RST;
      act_frc_a_r <= `LARS_I_ZERO;
      act_frc_b_r <= `LARS_I_ZERO;
      act_src_r <= 7'h00;
      act_gain_a_r <= 16'h0000;
      act_gain_b_r <= 16'h0000;
      act_times_r <= 16'h0000;
      act_limen_r <= 13'h0000;
      for (i = 0; i < 5; i = i + 1) begin
        act_lo_r[i] <= 16'h0000;
        act_hi_r[i] <= 16'h0000;
      end
    end else if (commit_r) begin
      act_loop_r <= sh_loop_r;
      act_frc_a_r <= sh_frc_a_r;
      act_frc_b_r <= sh_frc_b_r;
      act_src_r <= sh_src_r;
      act_gain_a_r <= sh_gain_a_r;
      act_gain_b_r <= sh_gain_b_r;
      act_times_r <= sh_times_r;
      act_limen_r <= sh_limen_r;
      for (i = 0; i < 5; i = i + 1) begin
        act_lo_r[i] <= sh_lo_r[i];
        act_hi_r[i] <= sh_hi_r[i];
      end
    end
  end

  // seconds tick and blink phase
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b0;
      blink_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (tick_cnt_r == TICK_CYCLES - 1) begin
        tick_cnt_r <= 32'h0000_0000;
        tick_r <= 1'b1;
        blink_r <= !blink_r;
      end else begin
        tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      end
    end
  end

  // pin synchronisers; the button edge uses the second and third stages only
  always @(posedge aclk) begin
    if (!aresetn) begin
      reach_a_r <= 2'h3;
      reach_b_r <= 2'h3;
      btn_r <= 3'h0;
    end else begin
      reach_a_r <= {reach_a_r[0], loop_a_reach_ok};
      reach_b_r <= {reach_b_r[0], loop_b_reach_ok};
      btn_r <= {btn_r[1:0], clear_button};
    end
  end
  wire clear_go = sw_clear_r || (btn_r[1] && !btn_r[2]);

  // alert and alarm per result
  wire [7:0] delay_s = act_times_r[7:0];
  wire [7:0] hold_s = act_times_r[15:8];
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : alm
      reg [7:0] dly_r, hold_r;
      reg alarm_r;
      reg [1:0] st;
      wire lo_en = act_limen_r[g];
      wire hi_en = act_limen_r[8 + g];
      wire lo_hit = lo_en && res[g] < act_lo_r[g];
      wire hi_hit = hi_en && res[g] > act_hi_r[g];
      wire alert = lo_hit || hi_hit;
      always @* begin
        if (!lo_en && !hi_en) st = `LARS_AL_DIS;
        else if (lo_hit) st = `LARS_AL_LOW;
        else if (hi_hit) st = `LARS_AL_HIGH;
        else st = `LARS_AL_OK;
      end
      always @(posedge aclk) begin
        if (!aresetn || clear_go) begin
          dly_r <= 8'h00;
          hold_r <= 8'h00;
          alarm_r <= 1'b0;
        end else if (!alarm_r) begin
          if (!alert) begin
            dly_r <= 8'h00;
          end else if (tick_r) begin
            if (dly_r >= delay_s) begin
              alarm_r <= 1'b1;
              hold_r <= 8'h00;
            end else begin
              dly_r <= dly_r + 8'h01;
            end
          end
        end else begin
          if (tick_r && hold_r != 8'hFF) hold_r <= hold_r + 8'h01;
          if (hold_r >= hold_s && !alert) begin
            alarm_r <= 1'b0;
            dly_r <= 8'h00;
          end
        end
      end
      assign alarm_w[g] = alarm_r;
      assign alert_w[2*g +: 2] = st;
    end
  endgenerate

  // loop current and faults
  wire frc_a = act_loop_r[`LARS_LOOP_FRC_A];
  wire frc_b = act_loop_r[`LARS_LOOP_FRC_B];
  wire en_a = act_loop_r[`LARS_LOOP_EN_A];
  wire en_b = act_loop_r[`LARS_LOOP_EN_B];
  wire [79:0] res_all = {result_4, result_3, result_2, result_1, result_0};
  wire [31:0] prod_a = pick(act_src_r[2:0], res_all) * act_gain_a_r;
  wire [31:0] prod_b = pick(act_src_r[6:4], res_all) * act_gain_b_r;
  wire [16:0] span_a = {1'b0, prod_a[31:16]};
  wire [16:0] span_b = {1'b0, prod_b[31:16]};
  // full scale is carried as a gain so no divider is needed
  wire [14:0] lin_a = (span_a > `LARS_I_SPAN) ? `LARS_I_FULL :
                      `LARS_I_BASE + span_a[14:0];
  wire [14:0] lin_b = (span_b > `LARS_I_SPAN) ? `LARS_I_FULL :
                      `LARS_I_BASE + span_b[14:0];
  wire fault_a = (en_a || frc_a) && !reach_a_r[1];
  wire fault_b = (en_b || frc_b) && !reach_b_r[1];
  wire coil = act_loop_r[`LARS_LOOP_FRC_RLY] ||
              |(alarm_w & act_loop_r[`LARS_LOOP_MAP_LSB +: 5]);
  wire any_frc = frc_a || frc_b || act_loop_r[`LARS_LOOP_FRC_RLY];

  always @(posedge aclk) begin
    if (!aresetn) begin
      loop_a_setpoint <= `LARS_I_ZERO;
      loop_b_setpoint <= `LARS_I_ZERO;
      relay_coil <= 1'b0;
      relay_no_closed <= 1'b0;
      relay_nc_closed <= 1'b1;
      power_lamp <= 1'b1;
      relay_lamp <= 1'b0;
      fault_lamp <= 1'b0;
      ui_activity <= 1'b0;
      relay_status_ind <= 1'b0;
    end else begin
      loop_a_setpoint <= frc_a ? act_frc_a_r : (en_a ? lin_a : `LARS_I_ZERO);
      loop_b_setpoint <= frc_b ? act_frc_b_r : (en_b ? lin_b : `LARS_I_ZERO);
      relay_coil <= coil;
      relay_no_closed <= coil;
      relay_nc_closed <= !coil;
      relay_lamp <= coil;
      power_lamp <= any_frc ? blink_r : 1'b1;
      ui_activity <= (frc_a || frc_b) && blink_r;
      fault_lamp <= (fault_a || fault_b) && blink_r;
      relay_status_ind <= act_loop_r[`LARS_LOOP_FRC_RLY] ? blink_r : coil;
    end
  end

  // read side
  wire rd_lo = s_axi_araddr[7:5] == `LARS_A_LO_BASE && s_axi_araddr[4:2] < 3'h5;
  wire rd_hi = s_axi_araddr[7:5] == `LARS_A_HI_BASE && s_axi_araddr[4:2] < 3'h5;
  always @* begin
    rd_nxt = 32'h0000_0000;
    rresp_nxt = `LARS_RESP_OK;
    case (s_axi_araddr)
      `LARS_A_CTRL: rd_nxt = 32'h0000_0000;
      `LARS_A_LOOP: rd_nxt = {19'h0, sh_loop_r};
      `LARS_A_FRC_A: rd_nxt = {17'h0, sh_frc_a_r};
      `LARS_A_FRC_B: rd_nxt = {17'h0, sh_frc_b_r};
      `LARS_A_SRC: rd_nxt = {25'h0, sh_src_r};
      `LARS_A_GAIN_A: rd_nxt = {16'h0, sh_gain_a_r};
      `LARS_A_GAIN_B: rd_nxt = {16'h0, sh_gain_b_r};
      `LARS_A_TIMES: rd_nxt = {16'h0, sh_times_r};
      `LARS_A_LIMEN: rd_nxt = {19'h0, sh_limen_r};
      `LARS_A_STAT: rd_nxt = {13'h0, fault_b, fault_a, relay_coil, 1'b0,
                              alarm_w, alert_w};
      `LARS_A_SETPT: rd_nxt = {1'b0, loop_b_setpoint, 1'b0, loop_a_setpoint};
      default: begin
        if (rd_lo) rd_nxt = {16'h0, sh_lo_r[s_axi_araddr[4:2]]};
        else if (rd_hi) rd_nxt = {16'h0, sh_hi_r[s_axi_araddr[4:2]]};
        else rresp_nxt = `LARS_RESP_ERR;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `LARS_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_nxt;
      s_axi_rresp <= rresp_nxt;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// File: verif/lars_checker.sv
`timescale 1ns/10ps
module lars_checker #(
  parameter TICK_CYCLES = 10
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire loop_a_reach_ok,
  input wire loop_b_reach_ok,
  input wire [14:0] loop_a_setpoint,
  input wire [14:0] loop_b_setpoint,
  input wire relay_coil,
  input wire relay_no_closed,
  input wire relay_nc_closed,
  input wire power_lamp,
  input wire relay_lamp,
  input wire fault_lamp,
  input wire relay_status_ind
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // pin sync plus lamp output register take three cycles to settle
  sequence reach_held;
    (loop_a_reach_ok && loop_b_reach_ok) [*8];
  endsequence
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  fault_lamp_a: assert property (reach_held |-> !fault_lamp)
    else $error("fault lamp lit while both loops reach set point");
  relay_contacts_a: assert property (
    relay_no_closed == relay_coil && relay_nc_closed == !relay_coil)
    else $error("relay contacts disagree with coil");
  relay_lamp_a: assert property (relay_lamp == relay_coil)
    else $error("relay lamp differs from coil");
  setpoint_range_a: assert property (
    loop_a_setpoint <= 15'h4E20 && loop_b_setpoint <= 15'h4E20)
    else $error("loop set point above full scale");
  reset_state_a: assert property ($rose(aresetn) |->
    loop_b_setpoint == 15'h0000 && !relay_coil && power_lamp)
    else $error("outputs not at reset state");
  status_ind_a: assert property (relay_status_ind |-> relay_coil)
    else $error("relay status lit without coil");
  write_answer_a: assert property (both_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
endmodule

// File: verif/lars_loop_rx.sv
`timescale 1ns/10ps
module lars_loop_rx #(
  parameter SETTLE = 1
) (
  input wire aclk,
  input wire [9:0] ohms,
  output wire reach_ok
);
  // compliance runs out above 500 ohms; an open loop is modelled as 1023 ohms
  reg [7:0] settle_r;
  always @(posedge aclk) begin
    settle_r <= {settle_r[6:0], ohms <= 10'h1F4};
  end
  assign reach_ok = settle_r[SETTLE-1];
endmodule

// File: verif/testbench.sv
`timescale 1ns/10ps
`include "lars_consts.vh"
module testbench;
  localparam T = 10;
  reg aclk, aresetn, clear_button;
  reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, rd_d;
  reg [1:0] rd_r, wr_b, en, e;
  reg [2:0] k;
  reg [15:0] v;
  reg [15:0] res [0:4];
  reg [9:0] ohm_a, ohm_b;
  reg [22:0] rows [0:7];
  reg [3:0] lamps_q;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire loop_a_reach_ok, loop_b_reach_ok, relay_coil, relay_no_closed, relay_nc_closed;
  wire power_lamp, relay_lamp, fault_lamp, ui_activity, relay_status_ind;
  wire [14:0] loop_a_setpoint, loop_b_setpoint;
  wire [3:0] lamps = {relay_status_ind, fault_lamp, ui_activity, power_lamp};
  int miscompares, comparisons, n, i, j, m;
  int tg [0:3];
  lars_top #(.TICK_CYCLES(T)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .result_0(res[0]), .result_1(res[1]), .result_2(res[2]), .result_3(res[3]),
    .result_4(res[4]), .loop_a_reach_ok, .loop_b_reach_ok, .clear_button,
    .loop_a_setpoint, .loop_b_setpoint, .relay_coil, .relay_no_closed,
    .relay_nc_closed, .power_lamp, .relay_lamp, .fault_lamp, .ui_activity,
    .relay_status_ind);
  lars_loop_rx #(.SETTLE(1)) rx_a (.aclk, .ohms(ohm_a), .reach_ok(loop_a_reach_ok));
  lars_loop_rx #(.SETTLE(4)) rx_b (.aclk, .ohms(ohm_b), .reach_ok(loop_b_reach_ok));
  initial begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end
  // blink counters run freely; the main sequence zeroes them before a look
  always @(negedge aclk) begin
    for (m = 0; m < 4; m++)
      if (lamps[m] !== lamps_q[m])
        tg[m]++;
    lamps_q = lamps;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons++;
      if (got !== exp) begin
        miscompares++;
        $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg ta, tw, da, dw;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      da = 0;
      dw = 0;
      while (!(da && dw)) begin
        @(negedge aclk);
        ta = s_axi_awready && !da;
        tw = s_axi_wready && !dw;
        @(posedge aclk);
        if (ta)
          s_axi_awvalid <= 1'b0;
        if (tw)
          s_axi_wvalid <= 1'b0;
        da = da || ta;
        dw = dw || tw;
      end
      ta = 0;
      while (!ta) begin
        @(negedge aclk);
        ta = s_axi_bvalid;
        wr_b = s_axi_bresp;
        @(posedge aclk);
      end
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    reg t;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      t = 0;
      while (!t) begin
        @(negedge aclk);
        t = s_axi_arready;
        @(posedge aclk);
      end
      s_axi_arvalid <= 1'b0;
      t = 0;
      while (!t) begin
        @(negedge aclk);
        t = s_axi_rvalid;
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
        @(posedge aclk);
      end
      s_axi_rready <= 1'b0;
    end
  endtask
  task cm;
    begin
      wr(`LARS_A_CTRL, 32'h0000_0001);
      repeat (4) @(posedge aclk);
    end
  endtask
  task coil_wait(input reg want);
    begin
      n = 0;
      while (relay_coil !== want && n < 5 * T) begin
        @(negedge aclk);
        n++;
      end
    end
  endtask
  task watch;
    begin
      for (j = 0; j < 4; j++)
        tg[j] = 0;
      repeat (3 * T) @(posedge aclk);
    end
  endtask
  task wrap_up;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    $display("[ERR] %0t run did not finish", $time);
    wrap_up;
  end
  initial begin
    {aresetn, clear_button, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0_0000;
    s_axi_wdata = 32'h0000_0000;
    ohm_a = 10'h0FA;
    ohm_b = 10'h3FF;
    miscompares = 0;
    comparisons = 0;
    for (i = 0; i < 5; i++)
      res[i] = 16'h0000;
    // result, {high en, low en}, value, alert code; limits are 100 and 200
    rows = '{{3'h0, 2'h0, 16'h0032, 2'h0}, {3'h1, 2'h1, 16'h0096, 2'h1},
      {3'h2, 2'h1, 16'h0032, 2'h2}, {3'h3, 2'h2, 16'h00FA, 2'h3},
      {3'h4, 2'h3, 16'h0096, 2'h1}, {3'h0, 2'h3, 16'h00FA, 2'h3},
      {3'h1, 2'h1, 16'h0064, 2'h1}, {3'h2, 2'h2, 16'h00C8, 2'h1}};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`LARS_A_LOOP);
    chk(rd_d, 32'h0000_0001);
    rd(`LARS_A_STAT);
    chk(rd_d[18:17], 2'h0);
    chk(loop_b_setpoint, 15'h0000);
    rd(8'h30);
    chk(rd_r, `LARS_RESP_ERR);
    wr(8'h30, 32'h0000_0001);
    chk(wr_b, `LARS_RESP_ERR);
    for (i = 0; i < 5; i++) begin
      wr(8'(8'h40 + 4 * i), 32'h0000_0064);
      wr(8'(8'h60 + 4 * i), 32'h0000_00C8);
    end
    chk(wr_b, `LARS_RESP_OK);
    for (i = 0; i < 8; i++) begin
      {k, en, v, e} = rows[i];
      res[k] <= v;
      wr(`LARS_A_LIMEN, ({31'h0, en[0]} << k) | ({31'h0, en[1]} << (k + 8)));
      cm;
      rd(`LARS_A_STAT);
      chk((rd_d >> (2 * k)) & 32'h3, e);
    end
    wr(`LARS_A_GAIN_A, 32'h0000_8000);
    res[0] <= 16'h1000;
    cm;
    chk(loop_a_setpoint, 15'h17A0);
    wr(`LARS_A_FRC_A, 32'h0000_2EE0);
    wr(`LARS_A_FRC_B, 32'h0000_4E20);
    wr(`LARS_A_LOOP, 32'h0000_000D);
    repeat (4) @(posedge aclk);
    chk(loop_a_setpoint, 15'h17A0);
    cm;
    chk(loop_a_setpoint, 15'h2EE0);
    chk(loop_b_setpoint, 15'h4E20);
    rd(`LARS_A_SETPT);
    chk(rd_d, 32'h4E20_2EE0);
    watch;
    chk(tg[0] >= 2 && tg[1] >= 2, 1);
    chk(tg[2] >= 2, 1);
    rd(`LARS_A_STAT);
    chk(rd_d[18:17], 2'h2);
    ohm_a <= 10'h258;
    repeat (12) @(posedge aclk);
    rd(`LARS_A_STAT);
    chk(rd_d[17], 1'b1);
    ohm_a <= 10'h0FA;
    // loop B now reaches so the fault lamp check gets both loops good
    ohm_b <= 10'h0C8;
    wr(`LARS_A_LOOP, 32'h0000_0001);
    cm;
    repeat (8) @(posedge aclk);
    rd(`LARS_A_STAT);
    chk({rd_d[18:17], power_lamp, ui_activity}, 4'h2);
    // delay 2 s, hold 3 s, high limit on result 1 mapped to the relay
    wr(`LARS_A_TIMES, 32'h0000_0302);
    wr(`LARS_A_LOOP, 32'h0000_0201);
    wr(`LARS_A_LIMEN, 32'h0000_0200);
    cm;
    wr(`LARS_A_CTRL, 32'h0000_0002);
    chk(relay_coil, 1'b0);
    res[1] <= 16'h0100;
    coil_wait(1'b1);
    chk(n > 2 * T && n <= 3 * T + 8, 1);
    @(posedge aclk);
    res[1] <= 16'h0000;
    coil_wait(1'b0);
    chk(n >= 3 * T - 4 && n <= 3 * T + 4, 1);
    @(posedge aclk);
    res[1] <= 16'h0100;
    coil_wait(1'b1);
    rd(`LARS_A_STAT);
    chk(rd_d[16:10], 7'h42);
    wr(`LARS_A_CTRL, 32'h0000_0002);
    repeat (2) @(posedge aclk);
    chk(relay_coil, 1'b0);
    coil_wait(1'b1);
    chk(n > 2 * T - 4 && n <= 3 * T + 8, 1);
    @(posedge aclk);
    clear_button <= 1'b1;
    repeat (4) @(posedge aclk);
    clear_button <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(relay_coil, 1'b0);
    res[1] <= 16'h0000;
    wr(`LARS_A_LOOP, 32'h0000_0011);
    cm;
    chk({relay_coil, relay_no_closed, relay_nc_closed, relay_lamp}, 4'hD);
    watch;
    chk(tg[0] >= 2 && tg[3] >= 2, 1);
    wrap_up;
  end
endmodule
bind lars_top lars_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .loop_a_reach_ok, .loop_b_reach_ok,
  .loop_a_setpoint, .loop_b_setpoint, .relay_coil, .relay_no_closed, .relay_nc_closed,
  .power_lamp, .relay_lamp, .fault_lamp, .relay_status_ind);
